// ==== evt_timer_pkg.sv ====
// Summary of operation
// [R1] Legacy route: timer0 to legacy 0, advanced 2
// [R2] Legacy route: timer1 to line 8 both
// [R3] Legacy route: timers 2,3 own field, 4-7 none
// [R4] Legacy route never blocks message delivery
// [R5] Standard route: timers 0-3 use own field
// [R6] Read-only capability field lists valid lines
// [R7] Timers 0,1 only lines 20-23, advanced only
// [R8] Timer2 adds line 11, timer3 adds 12
// [R9] Timers 4-7 deliver by message only
// [R10] Software sets edge mode before message use
// [R11] Message writes programmed payload to programmed address
// [R12] Message enable excludes controller lines, even legacy
// [R13] One-shot fires on equality, again after wrap
// [R14] One-shot never changes comparator in hardware
// [R15] Direct-load flag lets next half load comparator
// [R16] Timer0 32-bit default, 64 optional; others 32
// [R17] Periodic match adds last written period
// [R18] New period applies at the next match
// [R19] Only timer0 periodic; capability bit reports it
// [R20] Global enable bit 0 at 10h gates all
// [R21] Legacy controller lines are active high
// [R22] Shared lines must be level triggered
// [R23] Main counter increments by one per clock
// [R24] 32-bit timers compare low 32 counter bits
package evt_timer_pkg;
    localparam int          NUM_TIMERS      = 8;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_GEN_CFG     = 12'h010;
    localparam logic [11:0] OFS_CNT_LO      = 12'h0F0;
    localparam logic [11:0] OFS_CNT_HI      = 12'h0F4;
    localparam logic [11:0] OFS_TMR_BASE    = 12'h100;
    localparam int          TMR_STRIDE_LOG2 = 5;
    localparam logic [2:0]  SUB_CFG         = 3'h0;
    localparam logic [2:0]  SUB_CAP         = 3'h1;
    localparam logic [2:0]  SUB_CMP_LO      = 3'h2;
    localparam logic [2:0]  SUB_CMP_HI      = 3'h3;
    localparam logic [2:0]  SUB_MSG_VAL     = 3'h4;
    localparam logic [2:0]  SUB_MSG_ADDR    = 3'h5;
    // ------------------------------------------------------------
    // General configuration fields
    // ------------------------------------------------------------
    localparam int          GEN_ENABLE_BIT  = 0;
    localparam int          GEN_LEGACY_BIT  = 1;
    // ------------------------------------------------------------
    // Timer configuration fields
    // ------------------------------------------------------------
    localparam int          CFG_LEVEL_BIT   = 1;
    localparam int          CFG_INT_EN_BIT  = 2;
    localparam int          CFG_PERIODIC_BIT = 3;
    localparam int          CFG_PER_CAP_BIT = 4;
    localparam int          CFG_SIZE64_BIT  = 5;
    localparam int          CFG_LOAD_BIT    = 6;
    localparam int          CFG_MODE32_BIT  = 8;
    localparam int          CFG_ROUTE_LSB   = 9;
    localparam int          CFG_MSG_EN_BIT  = 14;
    localparam int          ROUTE_W         = 5;
    localparam logic [31:0] CFG_RESET       = 32'h0000_0000;
    // ------------------------------------------------------------
    // Controller line numbers and capability masks
    // ------------------------------------------------------------
    localparam logic [4:0]  LINE_TMR0_LEG   = 5'h00;
    localparam logic [4:0]  LINE_TMR0_ADV   = 5'h02;
    localparam logic [4:0]  LINE_TMR1       = 5'h08;
    localparam logic [4:0]  LINE_TMR2       = 5'h0B;
    localparam logic [4:0]  LINE_TMR3       = 5'h0C;
    localparam logic [31:0] CAP_ADV_ONLY    = 32'h00F0_0000;
    localparam logic [31:0] CAP_TMR2        = 32'h00F0_0800;
    localparam logic [31:0] CAP_TMR3        = 32'h00F0_1000;
    localparam logic [31:0] CAP_NONE        = 32'h0000_0000;
    localparam logic [31:0] LEGACY_LINES    = 32'h0000_1FFF;
endpackage

// ==== evt_comparator.sv ====
module evt_comparator
    import evt_timer_pkg::*;
#(
    parameter bit IS_TIMER0 = 1'b0
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // Counter and control
    input  wire logic [63:0] count,
    input  wire logic        enable,
    input  wire logic        periodic,
    input  wire logic        wide,
    // Software comparator writes
    input  wire logic        wr_lo,
    input  wire logic        wr_hi,
    input  wire logic        direct_load,
    input  wire logic [31:0] wdata,
    // Results
    output logic      [63:0] match_value,
    output logic             hit
);
    logic [63:0] period;
    logic [63:0] next_match_value;
    logic [63:0] next_period;
    logic        use64;

    assign use64 = IS_TIMER0 && wide; // [R16]
    // Narrow timers see only the low counter half
    assign hit = enable && (use64 ? (count == match_value)
                                  : (count[31:0] == match_value[31:0])); // [R24] [R13]

    always_comb begin
        next_match_value = match_value;
        next_period      = period;
        if (wr_lo || wr_hi) begin
            // Periodic writes set the increment; direct load sets the value
            if (IS_TIMER0 && periodic && !direct_load) begin
                if (wr_lo) next_period[31:0] = wdata; // [R18]
                else       next_period[63:32] = wdata;
            end else begin
                if (wr_lo) next_match_value[31:0] = wdata; // [R15]
                else       next_match_value[63:32] = wdata;
                if (IS_TIMER0 && wr_lo) next_period[31:0] = wdata;
                if (IS_TIMER0 && wr_hi) next_period[63:32] = wdata;
            end
        end else if (hit && IS_TIMER0 && periodic) begin
            next_match_value = match_value + period; // [R17]
        end
        // One-shot: hardware leaves the value alone [R14]
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            match_value <= 64'hFFFF_FFFF_FFFF_FFFF;
            period      <= 64'h0000_0000_0000_0000;
        end else if (clk_en) begin
            match_value <= next_match_value;
            period      <= next_period;
        end
    end

    AST_ONESHOT_HOLD: assert property (@(posedge mclk) disable iff (!rst_n) // [R14]
        clk_en && !periodic && !wr_lo && !wr_hi |=> $stable(match_value))
        else $error("one-shot comparator changed by hardware");
endmodule

// ==== evt_msg_port.sv ====
module evt_msg_port
    import evt_timer_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // Requests per timer
    input  wire logic [7:0]  req,
    input  wire logic [255:0] addr_flat,
    input  wire logic [255:0] val_flat,
    // Message write channel
    output logic             msg_valid,
    output logic      [31:0] msg_addr,
    output logic      [31:0] msg_data,
    input  wire logic        msg_ready
);
    logic [7:0]  pend;
    logic [7:0]  next_pend;
    logic [31:0] next_addr;
    logic [31:0] next_data;
    logic        next_valid;
    logic [2:0]  pick;
    logic        any;

    // Lowest pending timer wins
    always_comb begin
        pick = 3'h0;
        any  = 1'b0;
        for (int i = NUM_TIMERS - 1; i >= 0; i--) begin
            if (pend[i] || req[i]) begin
                pick = 3'(i);
                any  = 1'b1;
            end
        end
    end

    always_comb begin
        next_pend  = pend | req;
        next_valid = msg_valid;
        next_addr  = msg_addr;
        next_data  = msg_data;
        if (msg_valid && msg_ready) next_valid = 1'b0;
        if ((!msg_valid || msg_ready) && any) begin
            next_valid = 1'b1;
            next_addr  = addr_flat[pick*32 +: 32]; // [R11]
            next_data  = val_flat[pick*32 +: 32];
            // A new event in the same cycle still wins
            next_pend[pick] = pend[pick] && req[pick];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pend      <= 8'h00;
            msg_valid <= 1'b0;
            msg_addr  <= 32'h0000_0000;
            msg_data  <= 32'h0000_0000;
        end else if (clk_en) begin
            pend      <= next_pend;
            msg_valid <= next_valid;
            msg_addr  <= next_addr;
            msg_data  <= next_data;
        end
    end

    AST_MSG_HOLD: assert property (@(posedge mclk) disable iff (!rst_n) // [R11]
        msg_valid && !msg_ready && clk_en |=> msg_valid && $stable(msg_addr))
        else $error("message dropped before accepted");
endmodule

// ==== evt_timer_top.sv ====
module evt_timer_top
    import evt_timer_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Controller lines
    output logic      [31:0] legacy_irq,
    output logic      [31:0] adv_irq,
    output logic             legacy_pit_mute,
    output logic             rtc_mute,
    // Processor message path
    output logic             msg_valid,
    output logic      [31:0] msg_addr,
    output logic      [31:0] msg_data,
    input  wire logic        msg_ready
);
    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic        ap_wr;
    logic        ap_rd;
    logic [11:0] ap_addr;
    logic        next_ap_wr;
    logic [11:0] next_ap_addr;
    logic [31:0] next_hrdata;
    logic [31:0] rd_mux;
    logic        take;

    assign take       = hsel && hready && htrans[1];
    assign hreadyout  = !ap_rd; // Reads take one wait state: hrdata is a flop
    assign hresp      = 1'b0;

    always_comb begin
        next_ap_wr   = take && hwrite;
        next_ap_addr = take ? haddr : ap_addr;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ap_wr   <= 1'b0;
            ap_rd   <= 1'b0;
            ap_addr <= 12'h000;
        end else if (clk_en) begin
            ap_wr   <= next_ap_wr;
            ap_rd   <= take && !hwrite;
            ap_addr <= next_ap_addr;
        end
    end

    // ------------------------------------------------------------
    // Global state and main counter
    // ------------------------------------------------------------
    logic [31:0] gen_cfg;
    logic [63:0] count;
    logic [31:0] next_gen_cfg;
    logic [63:0] next_count;
    logic        enable;
    logic        legacy;

    assign enable = gen_cfg[GEN_ENABLE_BIT];
    assign legacy = gen_cfg[GEN_LEGACY_BIT];

    always_comb begin
        next_gen_cfg = gen_cfg;
        next_count   = count;
        if (enable) next_count = count + 64'h1; // [R23] [R20]
        if (ap_wr && ap_addr == OFS_GEN_CFG) begin
            next_gen_cfg = {30'h0, hwdata[GEN_LEGACY_BIT], hwdata[GEN_ENABLE_BIT]};
        end
        if (ap_wr && ap_addr == OFS_CNT_LO) next_count[31:0]  = hwdata;
        if (ap_wr && ap_addr == OFS_CNT_HI) next_count[63:32] = hwdata;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gen_cfg <= 32'h0000_0000;
            count   <= 64'h0000_0000_0000_0000;
        end else if (clk_en) begin
            gen_cfg <= next_gen_cfg;
            count   <= next_count;
        end
    end

    // ------------------------------------------------------------
    // Per-timer registers, comparators and routing
    // ------------------------------------------------------------
    logic [31:0]  cfg      [NUM_TIMERS];
    logic [31:0]  cap      [NUM_TIMERS];
    logic [63:0]  cmp      [NUM_TIMERS];
    logic [31:0]  mval     [NUM_TIMERS];
    logic [31:0]  maddr    [NUM_TIMERS];
    logic [7:0]   hit;
    logic [7:0]   msg_req;
    logic [7:0]   edge_q;
    logic [7:0]   level_q;
    logic [255:0] addr_flat;
    logic [255:0] val_flat;
    logic [31:0]  leg_vec  [NUM_TIMERS];
    logic [31:0]  adv_vec  [NUM_TIMERS];
    logic         tsel     [NUM_TIMERS];
    logic [2:0]   sub;

    assign sub = ap_addr[4:2];

    generate
        for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_tmr
            logic [31:0] next_cfg;
            logic [31:0] next_mval;
            logic [31:0] next_maddr;
            logic        next_level;
            logic        next_edge;
            logic        wr_cmp_lo;
            logic        wr_cmp_hi;
            logic        fire;
            logic        msg_on;
            logic [4:0]  route;

            assign tsel[t] = ap_addr[11:TMR_STRIDE_LOG2]
                             == 7'((OFS_TMR_BASE >> TMR_STRIDE_LOG2) + t);
            // Capability is fixed wiring
            assign cap[t] = (t < 2) ? CAP_ADV_ONLY :
                            (t == 2) ? CAP_TMR2 :
                            (t == 3) ? CAP_TMR3 : CAP_NONE; // [R6] [R7] [R8] [R9]
            assign wr_cmp_lo = ap_wr && tsel[t] && sub == SUB_CMP_LO;
            assign wr_cmp_hi = ap_wr && tsel[t] && sub == SUB_CMP_HI;
            assign fire      = hit[t] && cfg[t][CFG_INT_EN_BIT];
            assign msg_on    = cfg[t][CFG_MSG_EN_BIT];
            assign route     = cfg[t][CFG_ROUTE_LSB +: ROUTE_W];

            always_comb begin
                next_cfg   = cfg[t];
                next_mval  = mval[t];
                next_maddr = maddr[t];
                if (ap_wr && tsel[t] && sub == SUB_CFG) begin
                    next_cfg = hwdata;
                    next_cfg[CFG_PER_CAP_BIT] = (t == 0); // [R19]
                    next_cfg[CFG_MODE32_BIT] = 1'b0;
                    if (t != 0) begin
                        next_cfg[CFG_PERIODIC_BIT] = 1'b0; // [R19]
                        next_cfg[CFG_SIZE64_BIT] = 1'b0;   // [R16]
                    end
                    // Lines outside the capability cannot be chosen
                    if (!cap[t][hwdata[CFG_ROUTE_LSB +: ROUTE_W]]) begin
                        next_cfg[CFG_ROUTE_LSB +: ROUTE_W] = route; // [R7] [R8]
                    end
                end
                // Direct-load flag lasts for one half write
                if (wr_cmp_lo || wr_cmp_hi) next_cfg[CFG_LOAD_BIT] = 1'b0; // [R15]
                if (ap_wr && tsel[t] && sub == SUB_MSG_VAL)  next_mval  = hwdata;
                if (ap_wr && tsel[t] && sub == SUB_MSG_ADDR) next_maddr = hwdata;
                // Level held until software clears it by config write
                next_level = level_q[t] | fire;
                if (ap_wr && tsel[t] && sub == SUB_CFG && !hwdata[CFG_LEVEL_BIT]) begin
                    next_level = fire;
                end
                if (ap_wr && ap_addr == OFS_GEN_CFG && hwdata[t + 16]) next_level = fire;
                next_edge = fire && !cfg[t][CFG_LEVEL_BIT];
            end

            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    cfg[t]     <= CFG_RESET | (32'(t == 0) << CFG_PER_CAP_BIT); // [R19]
                    mval[t]    <= 32'h0000_0000;
                    maddr[t]   <= 32'h0000_0000;
                    level_q[t] <= 1'b0;
                    edge_q[t]  <= 1'b0;
                end else if (clk_en) begin
                    cfg[t]     <= next_cfg;
                    mval[t]    <= next_mval;
                    maddr[t]   <= next_maddr;
                    level_q[t] <= next_level && cfg[t][CFG_LEVEL_BIT];
                    edge_q[t]  <= next_edge;
                end
            end

            evt_comparator #(
                .IS_TIMER0   (t == 0)
            ) u_cmp (
                .mclk        (mclk),
                .rst_n       (rst_n),
                .clk_en      (clk_en),
                .count       (count),
                .enable      (enable), // [R20]
                .periodic    (cfg[t][CFG_PERIODIC_BIT]),
                .wide        (cfg[t][CFG_SIZE64_BIT]),
                .wr_lo       (wr_cmp_lo),
                .wr_hi       (wr_cmp_hi),
                .direct_load (cfg[t][CFG_LOAD_BIT]),
                .wdata       (hwdata),
                .match_value (cmp[t]),
                .hit         (hit[t])
            );

            assign msg_req[t] = fire && msg_on; // [R4] [R11]
            assign addr_flat[t*32 +: 32] = maddr[t];
            assign val_flat[t*32 +: 32]  = mval[t];

            // Line steering; message mode owns the timer entirely
            always_comb begin
                leg_vec[t] = 32'h0000_0000;
                adv_vec[t] = 32'h0000_0000;
                if (!msg_on && (level_q[t] || edge_q[t])) begin // [R12]
                    if (legacy && t == 0) begin
                        leg_vec[t][LINE_TMR0_LEG] = 1'b1; // [R1]
                        adv_vec[t][LINE_TMR0_ADV] = 1'b1;
                    end else if (legacy && t == 1) begin
                        leg_vec[t][LINE_TMR1] = 1'b1; // [R2]
                        adv_vec[t][LINE_TMR1] = 1'b1;
                    end else if (t < 4) begin
                        // Per-field routing [R3] [R5]
                        adv_vec[t][route] = cap[t][route];
                        leg_vec[t][route] = cap[t][route] && LEGACY_LINES[route];
                    end
                end
            end
        end
    endgenerate

    // Shared lines are a wired OR; safe only for level mode
    always_comb begin
        legacy_irq = 32'h0000_0000;
        adv_irq    = 32'h0000_0000;
        for (int t = 0; t < NUM_TIMERS; t++) begin
            legacy_irq = legacy_irq | leg_vec[t]; // [R21] [R22]
            adv_irq    = adv_irq | adv_vec[t];
        end
    end

    assign legacy_pit_mute = legacy; // [R1]
    assign rtc_mute        = legacy; // [R2]

    evt_msg_port u_msg (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .req       (msg_req),
        .addr_flat (addr_flat),
        .val_flat  (val_flat),
        .msg_valid (msg_valid),
        .msg_addr  (msg_addr),
        .msg_data  (msg_data),
        .msg_ready (msg_ready)
    );

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (ap_addr == OFS_GEN_CFG) rd_mux = gen_cfg;
        else if (ap_addr == OFS_CNT_LO) rd_mux = count[31:0];
        else if (ap_addr == OFS_CNT_HI) rd_mux = count[63:32];
        for (int t = 0; t < NUM_TIMERS; t++) begin
            if (tsel[t]) begin
                case (sub)
                    SUB_CFG:      rd_mux = cfg[t];
                    SUB_CAP:      rd_mux = cap[t]; // [R6]
                    SUB_CMP_LO:   rd_mux = cmp[t][31:0];
                    SUB_CMP_HI:   rd_mux = cmp[t][63:32];
                    SUB_MSG_VAL:  rd_mux = mval[t];
                    SUB_MSG_ADDR: rd_mux = maddr[t];
                    default:      rd_mux = 32'h0000_0000;
                endcase
            end
        end
        next_hrdata = ap_rd ? rd_mux : hrdata;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) hrdata <= 32'h0000_0000;
        else if (clk_en) hrdata <= next_hrdata;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_COUNT_STEP: assert property (@(posedge mclk) disable iff (!rst_n) // [R23]
        clk_en && enable && !ap_wr |=> count == $past(count) + 64'h1)
        else $error("main counter did not step by one");
    AST_DISABLED_HOLD: assert property (@(posedge mclk) disable iff (!rst_n) // [R20]
        clk_en && !enable && !ap_wr |=> $stable(count))
        else $error("counter moved while disabled");
    AST_NO_HIT_OFF: assert property (@(posedge mclk) disable iff (!rst_n) // [R20]
        clk_en && !enable |=> edge_q == 8'h00)
        else $error("timer pulse while globally disabled");
    AST_UPPER_NOLINE: assert property (@(posedge mclk) disable iff (!rst_n) // [R9]
        (leg_vec[4] | leg_vec[5] | leg_vec[6] | leg_vec[7]
         | adv_vec[4] | adv_vec[5] | adv_vec[6] | adv_vec[7]) == 32'h0)
        else $error("timers 4-7 reached a controller line");
    AST_MSG_EXCL: assert property (@(posedge mclk) disable iff (!rst_n) // [R12]
        cfg[0][CFG_MSG_EN_BIT] |-> leg_vec[0] == 32'h0 && adv_vec[0] == 32'h0)
        else $error("message timer drove a line");
    AST_LEG_T0: assert property (@(posedge mclk) disable iff (!rst_n) // [R1]
        legacy && !cfg[0][CFG_MSG_EN_BIT] && (level_q[0] || edge_q[0])
        |-> legacy_irq[0] && adv_irq[2])
        else $error("legacy timer 0 routing wrong");
    AST_LEG_T1: assert property (@(posedge mclk) disable iff (!rst_n) // [R2]
        legacy && !cfg[1][CFG_MSG_EN_BIT] && (level_q[1] || edge_q[1])
        |-> legacy_irq[8] && adv_irq[8])
        else $error("legacy timer 1 routing wrong");
    AST_MSG_SENT: assert property (@(posedge mclk) disable iff (!rst_n) // [R11]
        clk_en && msg_req[4] && !msg_valid && msg_req[3:0] == 4'h0 && u_msg.pend == 8'h0
        |=> msg_valid && msg_addr == $past(maddr[4]) && msg_data == $past(mval[4]))
        else $error("message not issued with programmed address and data");
    AST_CAP_FIXED: assert property (@(posedge mclk) disable iff (!rst_n) // [R7] [R8]
        cap[0] == CAP_ADV_ONLY && cap[2] == CAP_TMR2 && cap[3] == CAP_TMR3)
        else $error("capability field changed");
    AST_LEVEL_HOLD: assert property (@(posedge mclk) disable iff (!rst_n) // [R22]
        clk_en && level_q[2] && cfg[2][CFG_LEVEL_BIT] && !ap_wr |=> level_q[2])
        else $error("level interrupt dropped without a clear");

    COV_LEGACY: cover property (@(posedge mclk) legacy && (level_q[0] || edge_q[0]));
    COV_MSG: cover property (@(posedge mclk) msg_valid && msg_ready);
    COV_PERIODIC: cover property (@(posedge mclk) hit[0] && cfg[0][CFG_PERIODIC_BIT]);
    COV_SHARED: cover property (@(posedge mclk) level_q[2] && level_q[3] && adv_irq[20]);
    COV_MSG_WAIT: cover property (@(posedge mclk) msg_valid && !msg_ready);
endmodule

// ==== msg_sink.sv ====
module msg_sink (
    // Message channel
    input  wire logic        mclk,
    input  wire logic        msg_valid,
    input  wire logic [31:0] msg_addr,
    input  wire logic [31:0] msg_data,
    output logic             msg_ready,
    // Observation
    output logic      [31:0] got_addr,
    output logic      [31:0] got_data,
    output int               got_count
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] slow = 2'h0;
    initial msg_ready = 1'b0;
    initial got_count = 0;
    // Ready one cycle in four, so the held write is exercised
    always @(posedge mclk) begin
        slow <= slow + 2'h1;
        msg_ready <= (slow == 2'h2);
        if (msg_valid && msg_ready) begin
            got_addr <= msg_addr;
            got_data <= msg_data;
            got_count <= got_count + 1;
        end
    end
endmodule

// ==== event_timer_irq_routing_tb_top.sv ====
module event_timer_irq_routing_tb_top;
    import evt_timer_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h0;
    logic [11:0] haddr = 12'h000;
    logic [31:0] hwdata = 32'h0, r;
    logic        seen0 = 1'b0, seen1 = 1'b0, stray = 1'b0;
    logic [31:0] hrdata, legacy_irq, adv_irq, msg_addr, msg_data, got_addr, got_data;
    logic        hreadyout, hresp, pit_mute, rtc_mute, msg_valid, msg_ready;
    int          got_count, fail_count = 0, comparisons = 0, cycles = 0;
    evt_timer_top DUT (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .legacy_irq(legacy_irq),
        .adv_irq(adv_irq), .legacy_pit_mute(pit_mute), .rtc_mute(rtc_mute),
        .msg_valid(msg_valid), .msg_addr(msg_addr), .msg_data(msg_data), .msg_ready(msg_ready));
    msg_sink sink (.mclk(mclk), .msg_valid(msg_valid), .msg_addr(msg_addr), .msg_data(msg_data),
        .msg_ready(msg_ready), .got_addr(got_addr), .got_data(got_data), .got_count(got_count));
    initial forever #50 mclk = ~mclk;
    // Lines seen while legacy routing is on; anything else is stray
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fail_count = fail_count + 1;
            conclude();
        end
        if (legacy_irq[0] && adv_irq[2]) seen0 <= 1'b1;
        if (legacy_irq[8] && adv_irq[8]) seen1 <= 1'b1;
        if ((legacy_irq & ~32'h0000_0101) | (adv_irq & ~32'h0000_0104)) stray <= 1'b1;
    end
    // ----------------------------------------
    // Bus and compare helpers
    // ----------------------------------------
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons = comparisons + 1;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            fail_count = fail_count + 1;
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_caps;
        for (int t = 0; t < 8; t++) begin
            bus(1'b0, OFS_TMR_BASE + 12'(t * 32) + 12'h004, 32'h0);
            chk("cap", t < 2 ? CAP_ADV_ONLY : t == 2 ? CAP_TMR2 : t == 3 ? CAP_TMR3 : CAP_NONE, r);
        end
    endtask
    task automatic t_gate;
        bus(1'b1, 12'h108, 32'h0000_0040);
        bus(1'b1, 12'h128, 32'h0000_0060);
        bus(1'b1, 12'h188, 32'h0000_0080);
        bus(1'b1, 12'h190, 32'hA5A5_0004);
        bus(1'b1, 12'h194, 32'h0FEE_0040);
        bus(1'b1, 12'h100, 32'h0000_0004);
        bus(1'b1, 12'h120, 32'h0000_0004);
        bus(1'b1, 12'h180, 32'h0000_4004);
        repeat (100) @(posedge mclk);
        bus(1'b0, OFS_CNT_LO, 32'h0);
        chk("halted count", 32'h0, r);
        chk("no line", 32'h0, {30'h0, seen0, seen1});
        bus(1'b1, OFS_GEN_CFG, 32'h0000_0003);
    endtask
    task automatic t_legacy;
        for (int i = 0; i < 400 && !(seen0 && seen1 && got_count > 0); i++) @(posedge mclk);
        chk("t0 lines", 32'h1, {31'h0, seen0});
        chk("t1 lines", 32'h1, {31'h0, seen1});
        chk("mutes", 32'h3, {30'h0, pit_mute, rtc_mute});
        chk("stray", 32'h0, {31'h0, stray});
        chk("msg addr", 32'h0FEE_0040, got_addr);
        chk("msg data", 32'hA5A5_0004, got_data);
        chk("msgs", 32'h1, 32'(got_count));
        bus(1'b0, 12'h108, 32'h0);
        chk("cmp kept", 32'h0000_0040, r);
    endtask
    task automatic t_route;
        bus(1'b1, OFS_GEN_CFG, 32'h0);
        bus(1'b1, OFS_CNT_LO, 32'h0);
        bus(1'b1, 12'h100, 32'h0000_1600);
        bus(1'b0, 12'h100, 32'h0);
        chk("t0 cfg", 32'h0000_0010, r);
        bus(1'b1, 12'h148, 32'h0000_0020);
        bus(1'b1, 12'h168, 32'h0000_0030);
        bus(1'b1, 12'h140, 32'h0000_2806);
        bus(1'b1, 12'h160, 32'h0000_2806);
        bus(1'b1, OFS_GEN_CFG, 32'h1);
        repeat (99) @(posedge mclk);
        chk("shared", 32'h0010_0000, adv_irq);
        chk("legacy", 32'h0, legacy_irq);
        bus(1'b1, OFS_GEN_CFG, 32'h000C_0001);
        @(posedge mclk);
        chk("cleared", 32'h0, adv_irq);
    endtask
    task automatic conclude;
        $display("fail_count %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        t_caps;
        t_gate;
        t_legacy;
        t_route;
        conclude;
    end
endmodule
